// File: sim/conv_source.sv
`timescale 1ns/100ps
// ****************************************
// Conversion source standing in for the analog front end
// ****************************************
module conv_source (
  input  wire logic        aclk,
  output logic             conv_valid,
  output logic      [1:0]  conv_channel,
  output logic      [15:0] conv_temp,
  output logic      [3:0]  conv_gain
);
  // Quiet lines before the first result
  initial begin
    conv_valid   = 1'b0;
    conv_channel = 2'h0;
    conv_temp    = 16'h0000;
    conv_gain    = 4'h0;
  end

  // One-cycle result pulse, stale lines inverted so nothing lingers
  task automatic send(input logic [1:0] ch, input logic [15:0] t, input logic [3:0] g);
    @(posedge aclk);
    conv_valid   <= 1'b1;
    conv_channel <= ch;
    conv_temp    <= t;
    conv_gain    <= g;
    @(posedge aclk);
    conv_valid   <= 1'b0;
    conv_channel <= ~ch;
    conv_temp    <= ~t;
    conv_gain    <= ~g;
    repeat (4) @(posedge aclk);
  endtask : send
endmodule : conv_source

// File: sim/testbench.sv
`timescale 1ns/100ps
// ****************************************
// Register and result checks for the post-processing block
// ****************************************
module testbench;
  typedef struct {logic [6:0] idx; logic [31:0] data; logic [1:0] resp;} note_t;
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        conv_valid;
  logic [1:0]  conv_channel;
  logic [15:0] conv_temp;
  logic [3:0]  conv_gain;
  logic [7:0]  configuration;
  logic [7:0]  ideality_value;
  logic [7:0]  ideality_select;
  logic [7:0]  gain_comp_enable;
  logic        irq;
  note_t       rq[$];
  logic [1:0]  bq[$];
  note_t       note;
  int          n_mismatch = 0;
  int          checks = 0;
  int          seed = 60600;
  int          c, k, t, pk, r3;
  int          raw[4];
  int          rf[4];
  int          hist[4];
  logic [7:0]  ov, v, sel;
  logic        first;

  temp_channel_postprocess_regs dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_temp(conv_temp), .conv_gain(conv_gain),
    .configuration(configuration), .ideality_value(ideality_value),
    .ideality_select(ideality_select), .gain_comp_enable(gain_comp_enable), .irq(irq)
  );

  conv_source src (
    .aclk(aclk), .conv_valid(conv_valid), .conv_channel(conv_channel),
    .conv_temp(conv_temp), .conv_gain(conv_gain)
  );

  // Clock at 125 MHz
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Verdict and end of run
  task automatic end_of_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // Register write, expected response noted for the monitor
  task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] rsp = temp_pkg::RESP_OKAY);
    bq.push_back(rsp);
    @(posedge aclk);
    awaddr  <= {3'h0, idx, 2'h0};
    awvalid <= 1'b1;
    wdata   <= {$random(seed)} & 32'hffffff00 | {24'h0, d};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  // Register read, expected data noted for the monitor
  task automatic rd(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] rsp = temp_pkg::RESP_OKAY);
    rq.push_back('{idx, {24'h0, d}, rsp});
    @(posedge aclk);
    araddr  <= {3'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  // Sixteen-bit value as high byte then low byte
  task automatic rd16(input logic [6:0] idx, input int val);
    rd(idx, val[15:8]);
    rd(idx + 7'h1, val[7:0]);
  endtask : rd16

  // Interrupt level after the last write has landed
  task automatic irq_is(input logic e);
    @(posedge aclk);
    chk("irq", 32'(e), 32'(irq));
  endtask : irq_is

  // Value after reset for each index
  function automatic logic [7:0] rst_val(input int i);
    case (i)
      8'h12: return 8'h0f;
      8'h13: return 8'h10;
      8'h14: return 8'h18;
      8'h16: return 8'h77;
      default: return 8'h00;
    endcase
  endfunction : rst_val

  // Monitor: oldest note against each answer
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      note = rq.pop_front();
      chk($sformatf("rdata %h", note.idx), note.data, rdata);
      chk($sformatf("rresp %h", note.idx), 32'(note.resp), 32'(rresp));
    end
    if (bvalid && bready) chk("bresp", 32'(bq.pop_front()), 32'(bresp));
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 8'h1d; k++) if (k < 8 || k >= 8'h10) rd(7'(k), rst_val(k));
    chk("configuration", 32'h10, 32'(configuration));
    chk("ideality_value", 32'h18, 32'(ideality_value));
    irq_is(1'b0);
    // Reserved bits, read-only and unmapped places
    foreach (sel[i]) if (i inside {1, 3, 4, 5}) begin
      wr(7'(8'h14 + i), 8'hff);
      rd(7'(8'h14 + i), 8'h0e);
      if (i == 1) chk("ideality_select", 32'h0e, 32'(ideality_select));
      wr(7'(8'h14 + i), 8'h00);
    end
    wr(7'h12, 8'hff);
    rd(7'h12, 8'h0f);
    v = $random(seed);
    wr(7'h13, v);
    rd(7'h13, v);
    chk("configuration", 32'(v), 32'(configuration));
    wstrb <= 4'he;
    wr(7'h13, ~v);
    wstrb <= 4'hf;
    rd(7'h13, v);
    v = $random(seed);
    wr(7'h14, v);
    rd(7'h14, v);
    chk("ideality_value", 32'(v), 32'(ideality_value));
    wr(7'h00, 8'hff);
    rd(7'h00, 8'h00);
    wr(7'h1a, 8'hff);
    rd(7'h1a, 8'h00);
    wr(7'h08, 8'hff, temp_pkg::RESP_SLVERR);
    rd(7'h08, 8'h00, temp_pkg::RESP_SLVERR);
    // Offset on remotes 1 and 3, results and highest value
    ov = $random(seed);
    wr(7'h16, ov);
    rd(7'h16, ov);
    wr(7'h17, 8'h0a);
    for (c = 0; c < 4; c++) begin
      raw[c] = $random(seed) % 8192;
      src.send(c[1:0], raw[c][15:0], 4'h0);
      r3 = raw[c] + ((c == 1 || c == 3) ? (int'(ov) - 119) * 32 : 0);
      rd16(7'(2 * c), r3);
    end
    for (c = 0; c < 4; c++) begin
      rf[c] = $random(seed) % 4096;
      wr(7'(8'h40 + 2 * c), rf[c][15:8]);
      wr(7'(8'h41 + 2 * c), rf[c][7:0]);
    end
    for (k = 0; k < 4; k++) begin
      sel = (k == 0) ? 8'h0f : (k == 1) ? 8'h05 : (k == 2) ? 8'h00 : 8'h0a;
      if (k > 0) wr(7'h12, sel);
      pk = 0;
      first = 1'b1;
      for (c = 0; c < 4; c++) if (sel[c] && (first || raw[c] - rf[c] > pk)) begin
        pk = raw[c] - rf[c];
        first = 1'b0;
      end
      rd16(7'h10, pk);
    end
    // Averaging on remote 3, offset enables cleared first
    wr(7'h17, 8'h00);
    wr(7'h18, 8'h08);
    rd16(7'h06, r3);
    for (k = 0; k < 5; k++) begin
      t = $random(seed) % 8192;
      if (k == 0) hist = '{t, t, t, t};
      else hist = '{hist[1], hist[2], hist[3], t};
      src.send(2'h3, t[15:0], 4'h0);
      rd16(7'h06, (hist[0] + hist[1] + hist[2] + hist[3]) >>> 2);
    end
    // Gain codes and low-gain fault on remote 1
    wr(7'h19, 8'h02);
    chk("gain_comp_enable", 32'h02, 32'(gain_comp_enable));
    for (k = 0; k < 10; k++) begin
      src.send(2'h1, 16'h0100, 4'(k));
      rd(7'h1a, 8'(k));
    end
    src.send(2'h2, 16'h0280, 4'hf);
    rd16(7'h04, 16'h0280);
    src.send(2'h1, 16'h0300, 4'hf);
    rd(7'h1a, 8'h0f);
    rd16(7'h02, 16'h0000);
    rd(7'h60, 8'h02);
    irq_is(1'b0);
    wr(7'h61, 8'h02);
    irq_is(1'b1);
    wr(7'h60, 8'h02);
    rd(7'h60, 8'h00);
    irq_is(1'b0);
    repeat (4) @(posedge aclk);
    end_of_test();
  end
endmodule : testbench

// File: verilog/temp_avg4.sv
`timescale 1ns/100ps
// ****************************************
// Running mean of the last four samples
// ****************************************
module temp_avg4 (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        enable,
  input  wire logic        in_valid,
  input  wire logic [15:0] in_sample,
  output logic             out_valid,
  output logic      [15:0] out_mean
);
  logic        primed;
  logic [15:0] h0;
  logic [15:0] h1;
  logic [15:0] h2;
  logic [17:0] sum;

  // Signed sum of new sample and three older ones
  assign sum = {{2{in_sample[15]}}, in_sample} + {{2{h0[15]}}, h0}
             + {{2{h1[15]}}, h1} + {{2{h2[15]}}, h2};

  // History fills with the first sample so older samples never enter the mean
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primed    <= 1'b0;
      h0        <= temp_pkg::TEMP_RST;
      h1        <= temp_pkg::TEMP_RST;
      h2        <= temp_pkg::TEMP_RST;
      out_valid <= 1'b0;
      out_mean  <= temp_pkg::TEMP_RST;
    end else begin
      out_valid <= in_valid;
      if (!enable) begin
        primed <= 1'b0;
      end
      if (in_valid) begin
        if (enable && primed) begin
          h2       <= h1;
          h1       <= h0;
          h0       <= in_sample;
          out_mean <= sum[17:2]; // Floor of sum over four
        end else begin
          h2       <= in_sample;
          h1       <= in_sample;
          h0       <= in_sample;
          out_mean <= in_sample;
        end
        if (enable) begin
          primed <= 1'b1;
        end
      end
    end
  end
endmodule : temp_avg4

// File: verilog/temp_channel_postprocess_regs.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
// Operation
// - Read-only gain code per remote, F is fault
// - Averaging bits 3..1 per remote, reset zero
// - Offset register 0.125 C steps, MSB 16 C
// - Applied offset is -14.875 C plus value/8
// - Offset register resets to 77h, zero net
// - Offset enable bits 3..1 add offset per remote
// - Highest temperature ignores the custom offset
// - Highest holds largest channel minus its reference
// - Channel select for highest resets to 0Fh
// - Results as high/low byte pairs 00h..07h
// - Ideality select per remote, resets nominal
// - Custom ideality register resets to 18h
// - Configuration register read-write, resets 10h
// - Reserved enable bits reset zero, no function
// - Averaging stores mean of last four results
// - Low gain fault: skip, flag, result 0000h
module temp_channel_postprocess_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        conv_valid,
  input  wire logic [1:0]  conv_channel,
  input  wire logic [15:0] conv_temp,
  input  wire logic [3:0]  conv_gain,
  output logic      [7:0]  configuration,
  output logic      [7:0]  ideality_value,
  output logic      [7:0]  ideality_select,
  output logic      [7:0]  gain_comp_enable,
  output logic             irq
);
  logic        aw_held;
  logic        w_held;
  logic [6:0]  aw_idx;
  logic [7:0]  wbyte;
  logic        wlane;
  logic        do_write;
  logic        wr_hit;
  logic        fault;
  logic [15:0] offset_term;
  logic [15:0] result [4];
  logic [15:0] raw [4];
  logic [15:0] refs [4];
  logic [7:0]  gain [3];
  logic [7:0]  peak_sel;
  logic [7:0]  offset_value;
  logic [7:0]  offset_channel_enable;
  logic [7:0]  averaging_enable;
  logic [3:0]  status;
  logic [3:0]  mask;
  logic [15:0] peak;
  logic [15:0] next_peak;
  logic [3:0]  avg_valid;
  logic [15:0] avg_mean [4];
  logic [8:0]  rd_word;
  logic [8:0]  wr_word;

  // ****************************************
  // Register read mux, bit 8 flags a mapped index
  // ****************************************
  function automatic logic [8:0] reg_read(input logic [6:0] idx);
    logic [8:0] r;
    r = {1'b1, 8'h00};
    if (idx <= temp_pkg::IDX_RESULT_LAST) begin
      r[7:0] = idx[0] ? result[idx[2:1]][7:0] : result[idx[2:1]][15:8];
    end else if (idx >= temp_pkg::IDX_GAIN_BASE && idx <= temp_pkg::IDX_GAIN_LAST) begin
      r[7:0] = gain[2'(idx - temp_pkg::IDX_GAIN_BASE)];
    end else if (idx >= temp_pkg::IDX_REF_BASE && idx <= temp_pkg::IDX_REF_LAST) begin
      r[7:0] = idx[0] ? refs[idx[2:1]][7:0] : refs[idx[2:1]][15:8];
    end else begin
      case (idx)
        temp_pkg::IDX_PEAK_HI:   r[7:0] = peak[15:8];
        temp_pkg::IDX_PEAK_LO:   r[7:0] = peak[7:0];
        temp_pkg::IDX_PEAK_SEL:  r[7:0] = peak_sel;
        temp_pkg::IDX_CONFIG:    r[7:0] = configuration;
        temp_pkg::IDX_IDEAL_VAL: r[7:0] = ideality_value;
        temp_pkg::IDX_IDEAL_SEL: r[7:0] = ideality_select;
        temp_pkg::IDX_OFFSET:    r[7:0] = offset_value;
        temp_pkg::IDX_OFFSET_EN: r[7:0] = offset_channel_enable;
        temp_pkg::IDX_AVG_EN:    r[7:0] = averaging_enable;
        temp_pkg::IDX_GAIN_COMP: r[7:0] = gain_comp_enable;
        temp_pkg::IDX_STATUS:    r[7:0] = {4'h0, status};
        temp_pkg::IDX_MASK:      r[7:0] = {4'h0, mask};
        default:                 r = 9'h000;
      endcase
    end
    return r;
  endfunction : reg_read

  // ****************************************
  // Write channel: address and data taken in either order
  // ****************************************
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit        = wr_word[8];

  // Decode of the held write index, reevaluated on register changes too
  always_comb begin
    wr_word = reg_read(aw_idx);
  end

  // Latch address and data until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 7'h00;
      wbyte   <= 8'h00;
      wlane   <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[8:2];
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        wbyte  <= s_axi_wdata[7:0];
        wlane  <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= temp_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? temp_pkg::RESP_OKAY : temp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Read channel, data from flip-flops
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  // Read word follows register contents, not only the address
  always_comb begin
    rd_word = reg_read(s_axi_araddr[8:2]);
  end

  // One read at a time, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= temp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_word[7:0]};
      s_axi_rresp  <= rd_word[8] ? temp_pkg::RESP_OKAY : temp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_sel              <= temp_pkg::PEAK_SEL_RST;
      configuration         <= temp_pkg::CONFIG_RST;
      ideality_value        <= temp_pkg::IDEAL_VAL_RST;
      ideality_select       <= temp_pkg::IDEAL_SEL_RST;
      offset_value          <= temp_pkg::OFFSET_RST;
      offset_channel_enable <= temp_pkg::CHAN_EN_RST;
      averaging_enable      <= temp_pkg::CHAN_EN_RST;
      gain_comp_enable      <= temp_pkg::CHAN_EN_RST;
      mask                  <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        refs[i] <= temp_pkg::TEMP_RST;
      end
    end else if (do_write && wlane) begin
      if (aw_idx >= temp_pkg::IDX_REF_BASE && aw_idx <= temp_pkg::IDX_REF_LAST) begin
        if (aw_idx[0]) begin
          refs[aw_idx[2:1]][7:0] <= wbyte;
        end else begin
          refs[aw_idx[2:1]][15:8] <= wbyte;
        end
      end
      case (aw_idx)
        temp_pkg::IDX_PEAK_SEL:  peak_sel <= wbyte & temp_pkg::PEAK_SEL_MASK;
        temp_pkg::IDX_CONFIG:    configuration <= wbyte;
        temp_pkg::IDX_IDEAL_VAL: ideality_value <= wbyte;
        temp_pkg::IDX_IDEAL_SEL: ideality_select <= wbyte & temp_pkg::REMOTE_MASK;
        temp_pkg::IDX_OFFSET:    offset_value <= wbyte;
        temp_pkg::IDX_OFFSET_EN: offset_channel_enable <= wbyte & temp_pkg::REMOTE_MASK;
        temp_pkg::IDX_AVG_EN:    averaging_enable <= wbyte & temp_pkg::REMOTE_MASK;
        temp_pkg::IDX_GAIN_COMP: gain_comp_enable <= wbyte & temp_pkg::REMOTE_MASK;
        temp_pkg::IDX_MASK:      mask <= wbyte[3:0] & temp_pkg::REMOTE_MASK[3:0];
        default:                 ;
      endcase
    end
  end

  // ****************************************
  // Conversion path
  // ****************************************
  // Low gain under compensation skips the measurement
  assign fault = conv_valid && (conv_channel != 2'd0)
              && gain_comp_enable[conv_channel] && (conv_gain == temp_pkg::GAIN_FAULT);

  // Offset in result units of 1/256 C, zero at 77h
  assign offset_term = 16'(({8'h00, offset_value} - {8'h00, temp_pkg::OFFSET_RST})
                       << temp_pkg::OFFSET_SHIFT);

  // One averager per channel, local bit is reserved so never averages
  generate
    for (genvar g = 0; g < 4; g++) begin : g_avg
      temp_avg4 u_avg (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .enable    (averaging_enable[g]),
        .in_valid  (conv_valid && (conv_channel == 2'(g)) && !fault),
        .in_sample (conv_temp),
        .out_valid (avg_valid[g]),
        .out_mean  (avg_mean[g])
      );
    end
  endgenerate

  // Results: raw copy for the peak, offset copy for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        result[i] <= temp_pkg::TEMP_RST;
        raw[i]    <= temp_pkg::TEMP_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (fault && (conv_channel == 2'(i))) begin
          result[i] <= 16'h0000;
          raw[i]    <= 16'h0000;
        end else if (avg_valid[i]) begin
          raw[i]    <= avg_mean[i];
          result[i] <= avg_mean[i] + (offset_channel_enable[i] ? offset_term : 16'h0000);
        end
      end
    end
  end

  // Gain code kept per remote, forced to fault code on low gain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        gain[i] <= temp_pkg::GAIN_RST;
      end
    end else if (conv_valid && (conv_channel != 2'd0) && gain_comp_enable[conv_channel]) begin
      gain[2'(conv_channel - 2'd1)] <= {4'h0, fault ? temp_pkg::GAIN_FAULT : conv_gain};
    end
  end

  // ****************************************
  // Highest temperature relative to reference
  // ****************************************
  always_comb begin
    logic signed [16:0] diff;
    logic signed [16:0] best;
    logic               any;
    diff = 17'sh00000;
    best = 17'sh00000;
    any  = 1'b0;
    for (int i = 0; i < 4; i++) begin
      diff = $signed({raw[i][15], raw[i]}) - $signed({refs[i][15], refs[i]});
      if (peak_sel[i] && (!any || diff > best)) begin
        best = diff;
        any  = 1'b1;
      end
    end
    if (best[16] != best[15]) begin
      next_peak = {best[16], {15{~best[16]}}};
    end else begin
      next_peak = best[15:0];
    end
  end

  // Peak reloads every cycle from offset-free values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak <= temp_pkg::TEMP_RST;
    end else begin
      peak <= next_peak;
    end
  end

  // ****************************************
  // Fault status and interrupt
  // ****************************************
  // Sticky fault bits, set wins over write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 4'h0;
    end else begin
      status <= (status & ~((do_write && wlane && aw_idx == temp_pkg::IDX_STATUS) ? wbyte[3:0] : 4'h0))
              | (fault ? 4'(4'h1 << conv_channel) : 4'h0);
    end
  end

  assign irq = |(status & mask);

  // ****************************************
  // Checks
  // ****************************************
  logic peak_cause;
  assign peak_cause = (|avg_valid) || fault || (do_write && aw_idx != temp_pkg::IDX_OFFSET
                      && aw_idx != temp_pkg::IDX_OFFSET_EN);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fault_result_zero: assert property (fault |=> result[$past(conv_channel)] == 16'h0000
    && status[$past(conv_channel)]) else $error("fault did not zero result");
  a_gain_fault_code: assert property (fault |=> gain[2'($past(conv_channel) - 2'd1)][3:0]
    == temp_pkg::GAIN_FAULT) else $error("gain register lacks fault code");
  a_offset_applied: assert property (avg_valid[1] && !(fault && conv_channel == 2'd1)
    |=> result[1] == $past(avg_mean[1]) + ($past(offset_channel_enable[1]) ? $past(offset_term)
    : 16'h0000)) else $error("remote 1 result offset wrong");
  a_offset_por_value: assert property ($rose(aresetn) |-> offset_value == 8'h77)
    else $error("offset not 77h after reset");
  a_peak_sel_por: assert property ($rose(aresetn) |-> peak_sel == 8'h0f)
    else $error("channel select not 0Fh after reset");
  a_enable_reserved_zero: assert property (((averaging_enable | offset_channel_enable)
    & 8'hf1) == 8'h00) else $error("reserved enable bit set");
  a_peak_no_offset: assert property ($changed(peak) |-> $past(peak_cause, 2))
    else $error("peak moved without a source change");
  a_read_result_byte: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[8:2] == 7'h00
    |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(result[0][15:8])})
    else $error("local high byte read wrong");
  a_reserved_read_zero: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[8:2] == temp_pkg::IDX_AVG_EN |=> (s_axi_rdata & ~32'h0000_000e) == 32'h0)
    else $error("reserved bits read nonzero");
  a_irq_on_fault: assert property (fault && mask[conv_channel] |=> irq)
    else $error("unmasked fault gave no interrupt");
endmodule : temp_channel_postprocess_regs

// File: verilog/temp_pkg.sv
// ****************************************
// Register indices, byte address is four times index
// ****************************************
package temp_pkg;
  localparam logic [6:0] IDX_RESULT_LAST = 7'h07;
  localparam logic [6:0] IDX_PEAK_HI     = 7'h10;
  localparam logic [6:0] IDX_PEAK_LO     = 7'h11;
  localparam logic [6:0] IDX_PEAK_SEL    = 7'h12;
  localparam logic [6:0] IDX_CONFIG      = 7'h13;
  localparam logic [6:0] IDX_IDEAL_VAL   = 7'h14;
  localparam logic [6:0] IDX_IDEAL_SEL   = 7'h15;
  localparam logic [6:0] IDX_OFFSET      = 7'h16;
  localparam logic [6:0] IDX_OFFSET_EN   = 7'h17;
  localparam logic [6:0] IDX_AVG_EN      = 7'h18;
  localparam logic [6:0] IDX_GAIN_COMP   = 7'h19;
  localparam logic [6:0] IDX_GAIN_BASE   = 7'h1a;
  localparam logic [6:0] IDX_GAIN_LAST   = 7'h1c;
  localparam logic [6:0] IDX_REF_BASE    = 7'h40;
  localparam logic [6:0] IDX_REF_LAST    = 7'h47;
  localparam logic [6:0] IDX_STATUS      = 7'h60;
  localparam logic [6:0] IDX_MASK        = 7'h61;

  // ****************************************
  // Values after reset and field masks
  // ****************************************
  localparam logic [7:0]  PEAK_SEL_RST  = 8'h0f;
  localparam logic [7:0]  CONFIG_RST    = 8'h10;
  localparam logic [7:0]  IDEAL_VAL_RST = 8'h18;
  localparam logic [7:0]  IDEAL_SEL_RST = 8'h00;
  localparam logic [7:0]  OFFSET_RST    = 8'h77;
  localparam logic [7:0]  CHAN_EN_RST   = 8'h00;
  localparam logic [15:0] TEMP_RST      = 16'h0000;
  localparam logic [7:0]  GAIN_RST      = 8'h00;
  localparam logic [7:0]  REMOTE_MASK   = 8'h0e;
  localparam logic [7:0]  PEAK_SEL_MASK = 8'h0f;
  localparam logic [3:0]  GAIN_FAULT    = 4'hf;
  localparam int          OFFSET_SHIFT  = 5;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : temp_pkg
